//--- dac_ctrl_assertions.sv
// Concurrent checks on the ports of the serial control bank.
// Assumes the bind at the foot attaches it to every bank instance.
`timescale 1ns/1ps

module dac_ctrl_assertions
  import dac_ctrl_pkg::*;
(
  input wire logic      mclk,
  input wire logic      reset,
  input wire logic      clk_en,
  input wire logic      sclk,
  input wire logic      cs_n,
  input wire logic      sdio_in,
  input wire logic      sdio_out,
  input wire logic      sdio_oe,
  input wire logic      core_regulator_status,
  input wire ctrl_t     ctrl,
  input wire pad_ctrl_t pad_ctrl
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  sequence s_cs_idle;
    cs_n [*6];
  endsequence
  sequence s_sclk_high;
    sclk [*7];
  endsequence

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  AST_OE_IDLE: assert property (s_cs_idle |-> !sdio_oe)
    else $error("sdio driven while deselected");
  AST_CTRL_STABLE: assert property (s_cs_idle |=> $stable(ctrl))
    else $error("control changed outside a frame");
  AST_OUT_STANDS: assert property (s_sclk_high |-> $stable(sdio_out))
    else $error("read data moved while serial clock high");
  AST_OE_IN_FRAME: assert property ($rose(sdio_oe) |->
    !cs_n && !$past(cs_n, 3))
    else $error("read driver enabled outside a frame");
  AST_RESET_DEFAULT: assert property (disable iff (1'b0)
    (reset && clk_en) |=> ctrl == 23'h000D00)
    else $error("control not at defaults after reset");
  AST_SOFT_HOLD: assert property (ctrl.soft_reset &&
    $past(ctrl.soft_reset) |-> ctrl[19:0] == 20'h00D00)
    else $error("registers left defaults under soft reset");
  AST_PAD_IN: assert property (pad_ctrl.data_clock_pad_in_en ==
    (ctrl.data_clock_input_enable & ~(ctrl.block_pad_bidirection &
    (ctrl.data_clock_output_enable | ctrl.data_clock_output_boost))))
    else $error("pad input enable wrong");
  AST_PAD_OUT: assert property ({pad_ctrl.data_clock_pad_out_en,
    pad_ctrl.data_clock_pad_boost_en} == {ctrl.data_clock_output_enable,
    ctrl.data_clock_output_boost})
    else $error("pad output enables wrong");
  AST_CLK_RUN: assert property ({pad_ctrl.i_converter_clock_run,
    pad_ctrl.q_converter_clock_run} == {~ctrl.i_converter_clock_gate &
    ~ctrl.full_power_down, ~ctrl.q_converter_clock_gate &
    ~ctrl.full_power_down})
    else $error("converter clock run wrong");
  AST_FREEZE: assert property (!clk_en |=> $stable(ctrl) &&
    $stable(sdio_oe) && $stable(sdio_out))
    else $error("state moved while clock enable low");
endmodule

bind dac_ctrl_regs dac_ctrl_assertions u_chk (
  .mclk(mclk), .reset(reset), .clk_en(clk_en), .sclk(sclk), .cs_n(cs_n),
  .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
  .core_regulator_status(core_regulator_status), .ctrl(ctrl),
  .pad_ctrl(pad_ctrl)
);

//--- dac_ctrl_pkg.sv
// Package for the dual converter serial control bank.
// Assumes one system clock domain; serial pins are synchronised in the block.
package dac_ctrl_pkg;

  // ----------------------------------------------------------------
  // Register offsets and layout
  // ----------------------------------------------------------------
  localparam logic [12:0] ADDR_SERIAL_PORT_CONFIG  = 13'h0000;
  localparam logic [12:0] ADDR_POWER_CONTROL       = 13'h0001;
  localparam logic [12:0] ADDR_INPUT_DATA_CONTROL  = 13'h0002;
  localparam logic [12:0] ADDR_I_CHANNEL_FINE_GAIN = 13'h0003;
  localparam int          NUM_REGS                 = 4;

  localparam logic [7:0] RST_SERIAL_PORT_CONFIG  = 8'h00;
  localparam logic [7:0] RST_POWER_CONTROL       = 8'h00;
  localparam logic [7:0] RST_INPUT_DATA_CONTROL  = 8'h34;
  localparam logic [7:0] RST_I_CHANNEL_FINE_GAIN = 8'h00;

  localparam logic [7:0] MASK_SERIAL_PORT_CONFIG  = 8'h70;
  localparam logic [7:0] MASK_POWER_CONTROL       = 8'hBF;
  localparam logic [7:0] MASK_INPUT_DATA_CONTROL  = 8'hBF;
  localparam logic [7:0] MASK_I_CHANNEL_FINE_GAIN = 8'h3F;

  localparam int BIT_LOW_BIT_FIRST   = 6;
  localparam int BIT_SOFT_RESET      = 5;
  localparam int BIT_LONG_INSTR      = 4;
  localparam int BIT_REG_DISABLE     = 7;
  localparam int BIT_REG_ON_FLAG     = 6;
  localparam int BIT_FULL_PDN        = 5;
  localparam int BIT_Q_CUR_DIS       = 4;
  localparam int BIT_I_CUR_DIS       = 3;
  localparam int BIT_Q_CLK_GATE      = 2;
  localparam int BIT_I_CLK_GATE      = 1;
  localparam int BIT_INT_REF_OFF     = 0;
  localparam int BIT_TWOS_FORMAT     = 7;
  localparam int BIT_I_LEADS_PAIR    = 5;
  localparam int BIT_I_ON_RISING     = 4;
  localparam int BIT_BLOCK_BIDIR     = 3;
  localparam int BIT_DCLK_IN_EN      = 2;
  localparam int BIT_DCLK_OUT_EN     = 1;
  localparam int BIT_DCLK_OUT_BOOST  = 0;

  // ----------------------------------------------------------------
  // Serial framing
  // ----------------------------------------------------------------
  localparam logic [4:0] SHORT_INSTR_BITS = 5'd8;
  localparam logic [4:0] LONG_INSTR_BITS  = 5'd16;
  localparam logic [4:0] DATA_BITS        = 5'd8;

  // Synchronised pin positions.
  localparam int PIN_SCLK   = 0;
  localparam int PIN_CS_N   = 1;
  localparam int PIN_SDIO   = 2;
  localparam int PIN_REG_OK = 3;
  localparam int NUM_PINS   = 4;

  typedef enum logic [1:0] {PH_IDLE, PH_INSTR, PH_DATA, PH_DONE} phase_t;

  typedef struct packed {
    logic       low_bit_first_order;
    logic       soft_reset;
    logic       long_instruction_select;
    logic       core_regulator_disable;
    logic       full_power_down;
    logic       q_output_current_disable;
    logic       i_output_current_disable;
    logic       q_converter_clock_gate;
    logic       i_converter_clock_gate;
    logic       internal_reference_off;
    logic       twos_complement_format;
    logic       i_sample_leads_pair;
    logic       i_on_rising_edge;
    logic       block_pad_bidirection;
    logic       data_clock_input_enable;
    logic       data_clock_output_enable;
    logic       data_clock_output_boost;
    logic [5:0] i_fine_gain_word;
  } ctrl_t;

  typedef struct packed {
    logic       data_clock_pad_in_en;
    logic       data_clock_pad_out_en;
    logic       data_clock_pad_boost_en;
    logic       i_converter_clock_run;
    logic       q_converter_clock_run;
  } pad_ctrl_t;

endpackage

//--- dac_ctrl_regs.sv
// Serial control register bank of a dual converter, addresses 0x00..0x03.
// Assumes sclk, cs_n, sdio and the regulator status arrive asynchronously
// and that sclk is far slower than mclk (idles low, data in on rising edge).
`timescale 1ns/1ps

module dac_ctrl_regs
  import dac_ctrl_pkg::*;
(
  input  wire logic      mclk,
  input  wire logic      reset,
  input  wire logic      clk_en,
  input  wire logic      sclk,
  input  wire logic      cs_n,
  input  wire logic      sdio_in,
  output      logic      sdio_out,
  output      logic      sdio_oe,
  input  wire logic      core_regulator_status,
  output      ctrl_t     ctrl,
  output      pad_ctrl_t pad_ctrl
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NUM_PINS-1:0] sync1;
    logic [NUM_PINS-1:0] sync2;
    logic [NUM_PINS-1:0] sync3;
    logic [NUM_PINS-1:0] level;
    phase_t              phase;
    logic [3:0]          bit_cnt;
    logic [15:0]         rx_sr;
    logic [7:0]          tx_sr;
    logic                rd;
    logic [12:0]         addr;
    logic [1:0]          bytes_left;
    logic                sdio_out;
    logic                sdio_oe;
    logic [NUM_REGS-1:0][7:0] regs;
  } state_t;

  // Synchroniser stages start at the idle pin levels (chip select high,
  // all else low), so no false chip select is seen just after reset.
  localparam logic [NUM_PINS-1:0] PIN_IDLE = 4'h2;

  localparam state_t STATE_RST = '{
    sync1:      PIN_IDLE,
    sync2:      PIN_IDLE,
    sync3:      PIN_IDLE,
    level:      PIN_IDLE,
    phase:      PH_IDLE,
    bit_cnt:    4'h0,
    rx_sr:      16'h0000,
    tx_sr:      8'h00,
    rd:         1'b0,
    addr:       13'h0000,
    bytes_left: 2'h0,
    sdio_out:   1'b0,
    sdio_oe:    1'b0,
    regs:       {RST_I_CHANNEL_FINE_GAIN, RST_INPUT_DATA_CONTROL,
                 RST_POWER_CONTROL, RST_SERIAL_PORT_CONFIG}
  };

  state_t st_ff;
  state_t nxt_st;

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic logic is_mapped(input logic [12:0] a);
    is_mapped = (a <= ADDR_I_CHANNEL_FINE_GAIN);
  endfunction

  function automatic logic [7:0] write_mask(input logic [1:0] idx);
    case (idx)
      2'h0:    write_mask = MASK_SERIAL_PORT_CONFIG;
      2'h1:    write_mask = MASK_POWER_CONTROL;
      2'h2:    write_mask = MASK_INPUT_DATA_CONTROL;
      default: write_mask = MASK_I_CHANNEL_FINE_GAIN;
    endcase
  endfunction

  function automatic logic [7:0] read_byte(
    input logic [NUM_REGS-1:0][7:0] r,
    input logic [12:0]              a,
    input logic                     reg_on
  );
    logic [7:0] v;
    v = 8'h00;
    if (is_mapped(a))
    begin
      v = r[a[1:0]] & write_mask(a[1:0]);
      if (a == ADDR_POWER_CONTROL)
      begin
        v[BIT_REG_ON_FLAG] = reg_on;
      end
    end
    read_byte = v;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic       sclk_rise;
  logic       sclk_fall;
  logic       lsb_first;
  logic [4:0] instr_len;
  logic [4:0] cur_len;
  logic [3:0] bit_pos;
  logic [15:0] rx_word;
  logic [7:0] wr_data;
  logic [1:0] idx;
  logic       rst_was_set;
  logic [12:0] addr_step;

  always_comb
  begin
    nxt_st = st_ff;
    // Pins pass three flip-flops; a change counts once stages 2 and 3 agree.
    nxt_st.sync1 = {core_regulator_status, sdio_in, cs_n, sclk};
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.sync3 = st_ff.sync2;
    for (int i = 0; i < NUM_PINS; i++)
    begin
      if (st_ff.sync2[i] == st_ff.sync3[i])
      begin
        nxt_st.level[i] = st_ff.sync2[i];
      end
    end
    sclk_rise = st_ff.sync2[PIN_SCLK] & st_ff.sync3[PIN_SCLK]
              & ~st_ff.level[PIN_SCLK];
    sclk_fall = ~st_ff.sync2[PIN_SCLK] & ~st_ff.sync3[PIN_SCLK]
              & st_ff.level[PIN_SCLK];

    // Port configuration is read live, so a write to it governs the very
    // next bit of the same transfer.
    lsb_first = st_ff.regs[0][BIT_LOW_BIT_FIRST];
    instr_len = st_ff.regs[0][BIT_LONG_INSTR] ? LONG_INSTR_BITS
                                              : SHORT_INSTR_BITS;
    cur_len   = (st_ff.phase == PH_INSTR) ? instr_len : DATA_BITS;
    bit_pos   = lsb_first ? st_ff.bit_cnt
                          : 4'(cur_len - 5'd1 - {1'b0, st_ff.bit_cnt});
    rx_word          = st_ff.rx_sr;
    rx_word[bit_pos] = st_ff.level[PIN_SDIO];
    wr_data          = rx_word[7:0];
    idx              = st_ff.addr[1:0];
    rst_was_set      = st_ff.regs[0][BIT_SOFT_RESET];
    addr_step        = lsb_first ? 13'(st_ff.addr + 13'd1)
                                 : 13'(st_ff.addr - 13'd1);

    if (st_ff.level[PIN_CS_N])
    begin
      nxt_st.phase   = PH_IDLE;
      nxt_st.sdio_oe = 1'b0;
    end
    else
    begin
      case (st_ff.phase)
        PH_IDLE:
        begin
          nxt_st.phase   = PH_INSTR;
          nxt_st.bit_cnt = 4'h0;
          nxt_st.rx_sr   = 16'h0000;
        end
        PH_INSTR:
        begin
          if (sclk_rise)
          begin
            nxt_st.rx_sr   = rx_word;
            nxt_st.bit_cnt = 4'(st_ff.bit_cnt + 4'd1);
            if ({1'b0, st_ff.bit_cnt} == 5'(instr_len - 5'd1))
            begin
              nxt_st.bit_cnt = 4'h0;
              nxt_st.rx_sr   = 16'h0000;
              nxt_st.phase   = PH_DATA;
              if (st_ff.regs[0][BIT_LONG_INSTR])
              begin
                nxt_st.rd         = rx_word[15];
                nxt_st.bytes_left = rx_word[14:13];
                nxt_st.addr       = rx_word[12:0];
              end
              else
              begin
                nxt_st.rd         = rx_word[7];
                nxt_st.bytes_left = rx_word[6:5];
                nxt_st.addr       = {8'h00, rx_word[4:0]};
              end
              nxt_st.tx_sr = read_byte(st_ff.regs, nxt_st.addr,
                                       st_ff.level[PIN_REG_OK]);
            end
          end
        end
        PH_DATA:
        begin
          if (sclk_fall && st_ff.rd)
          begin
            nxt_st.sdio_oe  = 1'b1;
            nxt_st.sdio_out = lsb_first ? st_ff.tx_sr[0] : st_ff.tx_sr[7];
            nxt_st.tx_sr    = lsb_first ? {1'b0, st_ff.tx_sr[7:1]}
                                        : {st_ff.tx_sr[6:0], 1'b0};
          end
          if (sclk_rise)
          begin
            nxt_st.rx_sr   = rx_word;
            nxt_st.bit_cnt = 4'(st_ff.bit_cnt + 4'd1);
            if ({1'b0, st_ff.bit_cnt} == 5'(DATA_BITS - 5'd1))
            begin
              nxt_st.bit_cnt = 4'h0;
              nxt_st.rx_sr   = 16'h0000;
              if (!st_ff.rd && is_mapped(st_ff.addr))
              begin
                nxt_st.regs[idx] =
                  (st_ff.regs[idx] & ~write_mask(idx))
                  | (wr_data & write_mask(idx));
              end
              nxt_st.addr  = addr_step;
              nxt_st.tx_sr = read_byte(nxt_st.regs, addr_step,
                                       st_ff.level[PIN_REG_OK]);
              if (st_ff.bytes_left == 2'h0)
              begin
                nxt_st.phase = PH_DONE;
              end
              else
              begin
                nxt_st.bytes_left = 2'(st_ff.bytes_left - 2'd1);
              end
              // A freshly set soft reset also resets the port: the rest of
              // this transfer is dropped and the next one starts clean.
              if (nxt_st.regs[0][BIT_SOFT_RESET] && !rst_was_set)
              begin
                nxt_st.phase = PH_DONE;
              end
            end
          end
        end
        PH_DONE:
        begin
          nxt_st.sdio_oe = 1'b0;
        end
        default:
        begin
          nxt_st.phase = PH_IDLE;
        end
      endcase
    end

    // While the soft reset bit stays one, every register but the port
    // configuration is held at its default value.
    if (nxt_st.regs[0][BIT_SOFT_RESET])
    begin
      nxt_st.regs[1] = RST_POWER_CONTROL;
      nxt_st.regs[2] = RST_INPUT_DATA_CONTROL;
      nxt_st.regs[3] = RST_I_CHANNEL_FINE_GAIN;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      st_ff <= STATE_RST;
    end
    else if (clk_en)
    begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign sdio_out = st_ff.sdio_out;
  assign sdio_oe  = st_ff.sdio_oe;

  // ----------------------------------------------------------------
  // Register views
  // ----------------------------------------------------------------
  logic [7:0] cfg_r;
  logic [7:0] pwr_r;
  logic [7:0] dat_r;

  assign cfg_r = st_ff.regs[0];
  assign pwr_r = st_ff.regs[1];
  assign dat_r = st_ff.regs[2];

  assign ctrl.low_bit_first_order      = cfg_r[BIT_LOW_BIT_FIRST];
  assign ctrl.soft_reset               = cfg_r[BIT_SOFT_RESET];
  assign ctrl.long_instruction_select  = cfg_r[BIT_LONG_INSTR];
  assign ctrl.core_regulator_disable   = pwr_r[BIT_REG_DISABLE];
  assign ctrl.full_power_down          = pwr_r[BIT_FULL_PDN];
  assign ctrl.q_output_current_disable = pwr_r[BIT_Q_CUR_DIS];
  assign ctrl.i_output_current_disable = pwr_r[BIT_I_CUR_DIS];
  assign ctrl.q_converter_clock_gate   = pwr_r[BIT_Q_CLK_GATE];
  assign ctrl.i_converter_clock_gate   = pwr_r[BIT_I_CLK_GATE];
  assign ctrl.internal_reference_off   = pwr_r[BIT_INT_REF_OFF];
  assign ctrl.twos_complement_format   = dat_r[BIT_TWOS_FORMAT];
  assign ctrl.i_sample_leads_pair      = dat_r[BIT_I_LEADS_PAIR];
  assign ctrl.i_on_rising_edge         = dat_r[BIT_I_ON_RISING];
  assign ctrl.block_pad_bidirection    = dat_r[BIT_BLOCK_BIDIR];
  assign ctrl.data_clock_input_enable  = dat_r[BIT_DCLK_IN_EN];
  assign ctrl.data_clock_output_enable = dat_r[BIT_DCLK_OUT_EN];
  assign ctrl.data_clock_output_boost  = dat_r[BIT_DCLK_OUT_BOOST];
  assign ctrl.i_fine_gain_word         = st_ff.regs[3][5:0];

  // When both pad directions are asked for and that is forbidden, the
  // output keeps the pad and the input is turned off.
  assign pad_ctrl.data_clock_pad_in_en =
    dat_r[BIT_DCLK_IN_EN]
    & ~(dat_r[BIT_BLOCK_BIDIR]
        & (dat_r[BIT_DCLK_OUT_EN]
           | dat_r[BIT_DCLK_OUT_BOOST]));
  assign pad_ctrl.data_clock_pad_out_en   = dat_r[BIT_DCLK_OUT_EN];
  assign pad_ctrl.data_clock_pad_boost_en =
    dat_r[BIT_DCLK_OUT_BOOST];
  assign pad_ctrl.i_converter_clock_run =
    ~pwr_r[BIT_I_CLK_GATE] & ~pwr_r[BIT_FULL_PDN];
  assign pad_ctrl.q_converter_clock_run =
    ~pwr_r[BIT_Q_CLK_GATE] & ~pwr_r[BIT_FULL_PDN];

endmodule

//--- spi_host_model.sv
// Serial host that frames instructions and data bytes for the bank.
// Assumes the bench resolves the shared data line and feeds it back.
`timescale 1ns/1ps

module spi_host_model (
  output logic      sclk,
  output logic      cs_n,
  output logic      sdio,
  input  wire logic sdio_line
);
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdio = 1'b0;
  end

  // A released line toggles so a stale level is never mistaken for data.
  task automatic send_bit(input logic v, input logic drv, output logic s);
    sdio = drv ? v : ~sdio;
    #62.5;
    sclk = 1'b1;
    s = sdio_line;
    #62.5;
    sclk = 1'b0;
  endtask

  task automatic xfer(input logic rd, lng, lsb, input logic [12:0] adr,
                      input logic [1:0] n, input logic [31:0] wd,
                      output logic [31:0] q);
    logic [15:0] ins;
    logic        s;
    int          nb;
    int          i;
    int          b;
    ins = lng ? {rd, n, adr} : {8'h00, rd, n, adr[4:0]};
    nb = lng ? 16 : 8;
    q = '0;
    #3.3;
    cs_n = 1'b0;
    #100;
    for (i = 0; i < nb; i++)
      send_bit(ins[lsb ? i : nb - 1 - i], 1'b1, s);
    for (i = 0; i < 8 * (n + 1); i++)
    begin
      b = 8 * (i / 8) + (lsb ? i % 8 : 7 - i % 8);
      send_bit(wd[b], !rd, s);
      q[b] = s;
    end
    #100;
    cs_n = 1'b1;
    sdio = ~sdio;
    #200;
  endtask
endmodule

//--- tb_top.sv
// Self-checking bench for the serial control bank.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps

module tb_top
  import dac_ctrl_pkg::*;
;
  logic        mclk;
  logic        reset;
  logic        clk_en;
  logic        sclk;
  logic        cs_n;
  logic        host_sdio;
  logic        sdio_in;
  logic        sdio_out;
  logic        sdio_oe;
  logic        reg_st;
  ctrl_t       ctrl;
  pad_ctrl_t   pad_ctrl;
  logic [7:0]  sh [4];
  logic        lsb_m;
  logic        lng_m;
  logic [31:0] q;
  int          error_cnt;
  int          compares;
  int          i;

  assign sdio_in = sdio_oe ? sdio_out : host_sdio;

  dac_ctrl_regs DUT (
    .mclk(mclk), .reset(reset), .clk_en(clk_en), .sclk(sclk), .cs_n(cs_n),
    .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .core_regulator_status(reg_st), .ctrl(ctrl), .pad_ctrl(pad_ctrl)
  );
  spi_host_model host (
    .sclk(sclk), .cs_n(cs_n), .sdio(host_sdio), .sdio_line(sdio_in)
  );

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // Reference model and checks
  // ----------------------------------------------------------------
  task automatic init_sh();
    sh = '{8'h00, 8'h00, 8'h34, 8'h00};
    lsb_m = 1'b0;
    lng_m = 1'b0;
  endtask

  task automatic upd(input logic [12:0] a, input logic [7:0] v);
    if (a == 13'h0)
    begin
      sh[0] = v & 8'h70;
      lsb_m = v[6];
      lng_m = v[4];
      if (v[5])
      begin
        sh[1] = RST_POWER_CONTROL;
        sh[2] = RST_INPUT_DATA_CONTROL;
        sh[3] = RST_I_CHANNEL_FINE_GAIN;
      end
    end
    else if (a < 13'h4 && !sh[0][5])
      sh[a[1:0]] = v & (a == 13'h3 ? 8'h3F : 8'hBF);
  endtask

  function automatic logic [7:0] rb(input logic [12:0] a);
    if (a > 13'h3)
      return 8'h00;
    if (a == 13'h1)
      return sh[1] | {1'b0, reg_st, 6'h00};
    return sh[a[1:0]];
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [12:0] a, input logic [1:0] n,
                    input logic [31:0] d);
    int k;
    host.xfer(1'b0, lng_m, lsb_m, a, n, d, q);
    for (k = 0; k <= n; k++)
      upd(13'(lsb_m ? a + k : a - k), d[8*k +: 8]);
  endtask

  task automatic rdchk(input logic [12:0] a, input logic [1:0] n);
    logic [31:0] e;
    int          k;
    e = '0;
    for (k = 0; k <= n; k++)
      e[8*k +: 8] = rb(13'(lsb_m ? a + k : a - k));
    host.xfer(1'b1, lng_m, lsb_m, a, n, 32'h0, q);
    chk("read", q, e);
  endtask

  task automatic chkctrl();
    chk("port", 32'(ctrl[22:20]), 32'(sh[0][6:4]));
    chk("power", 32'(ctrl[19:13]), 32'({sh[1][7], sh[1][5:0]}));
    chk("data", 32'(ctrl[12:6]), 32'({sh[2][7], sh[2][5:0]}));
    chk("gain", 32'(ctrl[5:0]), 32'(sh[3][5:0]));
  endtask

  task automatic results();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic do_reset();
    @(negedge mclk);
    reset = 1'b1;
    repeat (5) @(negedge mclk);
    reset = 1'b0;
    init_sh();
    repeat (8) @(negedge mclk);
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    #400000;
    error_cnt++;
    results();
  end

  initial
  begin
    error_cnt = 0;
    compares = 0;
    reset = 1'b1;
    clk_en = 1'b1;
    reg_st = 1'b1;
    init_sh();
    void'($urandom(32'h9364cb53));
    do_reset();
    chkctrl();
    rdchk(13'h3, 2'd3);
    $display("defaults done");
    for (i = 0; i < 8; i++)
    begin
      @(negedge mclk);
      reg_st = 1'($urandom);
      wr(13'h3, 2'd2, $urandom);
      chkctrl();
      rdchk(13'h3, 2'd2);
    end
    rdchk(13'h9, 2'd0);
    $display("random writes done");
    wr(13'h0, 2'd0, 32'h40);
    chkctrl();
    rdchk(13'h1, 2'd2);
    wr(13'h0, 2'd0, 32'h50);
    wr(13'h1, 2'd2, $urandom);
    chkctrl();
    rdchk(13'h0, 2'd3);
    $display("order and width done");
    wr(13'h0, 2'd0, 32'h70);
    chkctrl();
    wr(13'h3, 2'd0, 32'h15);
    chkctrl();
    wr(13'h0, 2'd0, 32'h00);
    chkctrl();
    rdchk(13'h3, 2'd3);
    $display("soft reset done");
    wr(13'h2, 2'd0, $urandom);
    do_reset();
    chkctrl();
    rdchk(13'h3, 2'd3);
    $display("mid-run reset done");
    @(negedge mclk);
    clk_en = 1'b0;
    host.xfer(1'b0, lng_m, lsb_m, 13'h2, 2'd0, $urandom, q);
    chkctrl();
    @(negedge mclk);
    clk_en = 1'b1;
    repeat (8) @(negedge mclk);
    chkctrl();
    rdchk(13'h2, 2'd0);
    $display("clock enable done");
    results();
  end
endmodule
